/* File: inc/fapg_map.vh */
`ifndef FAPG_MAP_VH
`define FAPG_MAP_VH

// Clock period of the internal time base in nanoseconds (100 ns).
`define FAPG_CLK_PERIOD_NS 32'h0000_0064
// One millisecond in nanoseconds.
`define FAPG_MS_NS 32'h000f_4240
// Milliseconds in one second of the time base.
`define FAPG_SECOND_MS 10'h3e8
// Width programming step in milliseconds (20 ms).
`define FAPG_STEP_MS 10'h014
// Reset width in steps: 5 steps of 20 ms gives 100 ms.
`define FAPG_WIDTH_RST_STEPS 6'h05
// Smallest programmable width in steps (20 ms).
`define FAPG_WIDTH_MIN_STEPS 6'h01
// Largest width in steps, once per second variant (980 ms).
`define FAPG_WIDTH_MAX_1PPS 6'h31
// Largest width in steps, five per second variant (180 ms).
`define FAPG_WIDTH_MAX_5PPS 6'h09
// Seconds of valid fix needed before edges count as aligned.
`define FAPG_ALIGN_SECS 3'h4
// Sentence slot index of the lead fix sentence in a record.
`define FAPG_SLOT_LEAD 3'h0

`endif

/* File: hw/fapg_ms_tick.v */
`timescale 1ns/100ps
// Millisecond prescaler; restart_i realigns the grid to an epoch.
module fapg_ms_tick #(
    parameter CYC_PER_MS = 10000,
    parameter CNT_W = 14
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire restart_i,
    output reg tick_o
);

    localparam [CNT_W-1:0] LAST = CYC_PER_MS - 1;

    reg [CNT_W-1:0] cnt;

    // A restart zeroes the count so every later tick sits a whole
    // number of milliseconds after the epoch.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (restart_i)
        begin
            cnt <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
        end
        else if (cnt == LAST)
        begin
            cnt <= {CNT_W{1'b0}};
            tick_o <= 1'b1;
        end
        else
        begin
            cnt <= cnt + {{(CNT_W-1){1'b0}}, 1'b1};
            tick_o <= 1'b0;
        end
    end

endmodule // fapg_ms_tick

/* File: hw/fapg_pulse_gen.v */
`timescale 1ns/100ps
`include "fapg_map.vh"
// Operation
// RULE1 - Pulse output stays low until first fix, then runs until power off.
// RULE2 - After 4 s valid fix, rising edges sit on the second start.
// RULE3 - One per second: width 100 ms default, 20 to 980 ms in 20 ms.
// RULE4 - Five per second: width 100 ms default, 20 to 180 ms in 20 ms.
// RULE5 - Five per second variant emits five pulses each second after fix.
// RULE6 - Host sets width via the sensor config sentence, thirteenth field.
// RULE7 - Record after each edge reports that edge; lead fix sentence first.
// RULE8 - Reported data refer to the edge just before the lead fix sentence.
// RULE9 - Edge alignment is only assured while a valid fix is computed.
// RULE10 - Host sets serial rate via the config sentence, tenth field.
// RULE11 - Pulse rises at the edge, falls after width in counted milliseconds.
module fapg_pulse_gen #(
    parameter PULSES_PER_SEC = 5,
    parameter CYC_PER_MS = `FAPG_MS_NS / `FAPG_CLK_PERIOD_NS
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire fix_valid_i,
    input wire second_start_i,
    input wire width_wr_i,
    input wire [5:0] width_steps_i,
    input wire sentence_done_i,
    output reg second_mark_pulse_o,
    output reg edge_snapshot_o,
    output reg record_start_o,
    output reg [2:0] sentence_slot_o,
    output reg [2:0] pulse_index_o,
    output reg aligned_o,
    output reg [5:0] width_steps_o,
    output reg width_reject_o
);

    localparam [9:0] PERIOD_MS = `FAPG_SECOND_MS / PULSES_PER_SEC;
    localparam [2:0] LAST_IDX = PULSES_PER_SEC - 1;
    localparam [5:0] MAX_STEPS = (PULSES_PER_SEC == 1) ?
        `FAPG_WIDTH_MAX_1PPS : `FAPG_WIDTH_MAX_5PPS;

    reg started;
    reg [9:0] per_ms;
    reg [9:0] hi_ms;
    reg [2:0] valid_secs;
    reg at_end;
    wire ms_tick;
    wire restart;
    wire wrap;
    wire mark_edge;
    wire [9:0] width_ms;
    wire [9:0] next_hi_ms;

    // A second start is only trusted while the fix is valid; without a
    // fix the counters free run on the internal time base instead.
    assign restart = second_start_i & fix_valid_i; // [RULE9]
    assign wrap = ms_tick & (per_ms == PERIOD_MS - 10'h001);
    // The last period of a second waits for the epoch while the fix
    // holds, so a free-run wrap never lands just before the real edge.
    assign mark_edge = (started | fix_valid_i) &
        (restart | (wrap & !(at_end & fix_valid_i))); // [RULE1] [RULE2]
    assign width_ms = {4'h0, width_steps_o} * `FAPG_STEP_MS;
    assign next_hi_ms = hi_ms + 10'h001;

    fapg_ms_tick #(
        .CYC_PER_MS(CYC_PER_MS),
        .CNT_W(14)
    ) u_tick (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .restart_i(restart),
        .tick_o(ms_tick)
    );

    // Once the first fix is seen the output never stops again.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            started <= 1'b0;
        else if (fix_valid_i)
            started <= 1'b1; // [RULE1]
    end

    // Count whole seconds of continuous valid fix for the aligned flag.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            valid_secs <= 3'h0;
            aligned_o <= 1'b0;
        end
        else if (!fix_valid_i)
        begin
            valid_secs <= 3'h0;
            aligned_o <= 1'b0; // [RULE9]
        end
        else if (second_start_i && valid_secs != `FAPG_ALIGN_SECS)
        begin
            valid_secs <= valid_secs + 3'h1;
            aligned_o <= (valid_secs + 3'h1) == `FAPG_ALIGN_SECS; // [RULE2]
        end
    end

    // Period and pulse index counters, reset to zero by the epoch.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            per_ms <= 10'h000;
            pulse_index_o <= 3'h0;
            at_end <= 1'b0;
        end
        else if (restart)
        begin
            per_ms <= 10'h000;
            pulse_index_o <= 3'h0; // [RULE2]
            at_end <= (LAST_IDX == 3'h0);
        end
        else if (wrap && !(at_end && fix_valid_i))
        begin
            per_ms <= 10'h000;
            if (at_end)
            begin
                pulse_index_o <= 3'h0;
                at_end <= (LAST_IDX == 3'h0);
            end
            else
            begin
                pulse_index_o <= pulse_index_o + 3'h1; // [RULE5]
                at_end <= (pulse_index_o + 3'h1) == LAST_IDX;
            end
        end
        else if (ms_tick && !wrap)
            per_ms <= per_ms + 10'h001;
    end

    // Pulse high from the edge until the width in milliseconds is spent.
    // The edge is one clock after the epoch strobe, well inside 1 us.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            second_mark_pulse_o <= 1'b0;
            hi_ms <= 10'h000;
        end
        else if (mark_edge)
        begin
            second_mark_pulse_o <= 1'b1; // [RULE11] [RULE5]
            hi_ms <= 10'h000;
        end
        else if (second_mark_pulse_o && ms_tick)
        begin
            hi_ms <= next_hi_ms;
            if (next_hi_ms >= width_ms)
                second_mark_pulse_o <= 1'b0; // [RULE11]
        end
    end

    // Width from the config sentence parser, in 20 ms steps. Values out
    // of range for this variant are refused and the old width is kept.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            width_steps_o <= `FAPG_WIDTH_RST_STEPS; // [RULE3] [RULE4]
            width_reject_o <= 1'b0;
        end
        else
        begin
            width_reject_o <= 1'b0;
            if (width_wr_i)
            begin
                if (width_steps_i >= `FAPG_WIDTH_MIN_STEPS &&
                    width_steps_i <= MAX_STEPS)
                    width_steps_o <= width_steps_i; // [RULE3] [RULE4]
                else
                    width_reject_o <= 1'b1;
            end
        end
    end

    // Each edge latches the time and position and opens a new record
    // whose first slot is the lead fix sentence. A new edge always
    // restarts the record, so data never refer to an older edge.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            edge_snapshot_o <= 1'b0;
            record_start_o <= 1'b0;
            sentence_slot_o <= `FAPG_SLOT_LEAD;
        end
        else
        begin
            edge_snapshot_o <= mark_edge; // [RULE8]
            record_start_o <= edge_snapshot_o; // [RULE7]
            if (mark_edge)
                sentence_slot_o <= `FAPG_SLOT_LEAD; // [RULE7] [RULE8]
            else if (sentence_done_i && sentence_slot_o != 3'h7)
                sentence_slot_o <= sentence_slot_o + 3'h1;
        end
    end

endmodule // fapg_pulse_gen

/* File: testbench/fapg_pulse_gen_monitor.sv */
`timescale 1ns/100ps
// Port-level watcher of pulse timing, record start and width writes.
module fapg_pulse_gen_monitor #(
    parameter PULSES_PER_SEC = 5,
    parameter CYC_PER_MS = 10000
) (
    input wire clk_i, rst_b_i, fix_valid_i, second_start_i, width_wr_i,
    input wire [5:0] width_steps_i,
    input wire sentence_done_i, second_mark_pulse_o, edge_snapshot_o,
    input wire record_start_o, aligned_o, width_reject_o,
    input wire [2:0] sentence_slot_o, pulse_index_o,
    input wire [5:0] width_steps_o
);
    localparam int MAXW = (PULSES_PER_SEC == 1) ? 49 : 9;
    reg seen_fix;
    reg [5:0] w_run;
    integer hi_cnt;
    // Width is latched while low and held through each pulse; the design takes a write in the next cycle.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            seen_fix <= 1'b0;
            w_run <= 6'h05;
            hi_cnt <= 0;
        end
        else
        begin
            seen_fix <= seen_fix | fix_valid_i;
            w_run <= second_mark_pulse_o ? w_run : width_steps_o;
            // A fresh edge while still high starts a new count.
            hi_cnt <= !second_mark_pulse_o ? 0 :
                edge_snapshot_o ? 1 : hi_cnt + 1;
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    sequence rec_seq;
        edge_snapshot_o && sentence_slot_o == 3'h0 ##1 record_start_o;
    endsequence
    AST_DARK: assert property (
        !seen_fix |-> !second_mark_pulse_o) else $error("pulse before fix");
    AST_ALIGN_EDGE: assert property (
        second_start_i && fix_valid_i |=> (second_mark_pulse_o &&
        pulse_index_o == 3'h0) ##0 rec_seq) else $error("edge missed");
    AST_RECORD: assert property (
        $rose(second_mark_pulse_o) |-> rec_seq) else $error("record late");
    AST_TAKE: assert property (
        width_wr_i && width_steps_i != 6'h00 && width_steps_i <= MAXW |=>
        width_steps_o == $past(width_steps_i) && !width_reject_o)
        else $error("width not taken");
    AST_REFUSE: assert property (
        width_wr_i && (width_steps_i == 6'h00 || width_steps_i > MAXW) |=>
        width_reject_o && $stable(width_steps_o)) else $error("bad width");
    AST_LEN: assert property (
        $fell(second_mark_pulse_o) |-> hi_cnt >= w_run * 20 * CYC_PER_MS - 1
        && hi_cnt <= w_run * 20 * CYC_PER_MS + 1) else $error("width wrong");
    AST_ALIGN_DROP: assert property (
        !fix_valid_i |=> !aligned_o) else $error("aligned without fix");
    AST_INDEX: assert property (
        pulse_index_o < PULSES_PER_SEC) else $error("pulse index range");
endmodule // fapg_pulse_gen_monitor

bind fapg_pulse_gen fapg_pulse_gen_monitor #(
    .PULSES_PER_SEC(PULSES_PER_SEC),
    .CYC_PER_MS(CYC_PER_MS)
) u_mon (.*);

/* File: testbench/fapg_host_model.sv */
`timescale 1ns/100ps
// Sentence emitter stand-in: three finished sentences per record.
module fapg_host_model (
    input wire clk_i,
    input wire rst_b_i,
    input wire record_start_i,
    output reg sentence_done_o
);
    integer cnt;
    // A new record restarts the pacing, as a new lead sentence would.
    // The pacing stands for whatever serial rate the host chose.
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt <= 0;
            sentence_done_o <= 1'b0;
        end
        else
        begin
            cnt <= record_start_i ? 1 : (cnt > 0 && cnt < 30) ? cnt + 1 : 0;
            sentence_done_o <= cnt > 0 && cnt % 10 == 0;
        end
    end
endmodule // fapg_host_model

/* File: testbench/fapg_pulse_gen_tb.sv */
`timescale 1ns/100ps
module fapg_pulse_gen_tb;
    localparam int CPM = 10;
    reg clk_i = 1'b0, rst_b_i = 1'b0, fix_valid_i = 1'b0;
    reg second_start_i = 1'b0, width_wr_i = 1'b0, last = 1'b0;
    reg [5:0] width_steps_i = 6'h00, cur, s;
    wire sentence_done_i, second_mark_pulse_o, edge_snapshot_o;
    wire record_start_o, aligned_o, width_reject_o;
    wire [2:0] sentence_slot_o, pulse_index_o;
    wire [5:0] width_steps_o;
    integer num_errors = 0, samples_checked = 0, seed = 77;
    integer rises = 0, hi = 0, k, r0, h0;
    // The 10 MHz time base.
    initial forever #50 clk_i = ~clk_i;
    fapg_pulse_gen #(.PULSES_PER_SEC(5), .CYC_PER_MS(CPM)) uut (.*);
    fapg_host_model host (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .record_start_i(record_start_o), .sentence_done_o(sentence_done_i));
    // Rising edges and high cycles are tallied for per-second checks.
    always @(posedge clk_i)
    begin
        last <= second_mark_pulse_o;
        rises <= rises + (second_mark_pulse_o && !last);
        hi <= hi + second_mark_pulse_o;
    end
    function automatic [5:0] next_width(input [5:0] old, input [5:0] req);
        next_width = (req != 6'h00 && req <= 6'h09) ? req : old;
    endfunction
    task check_val(input [5:0] got, input [5:0] exp);
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            num_errors = num_errors + 1;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task check_cnt(input integer got, input integer exp, input integer tol);
        samples_checked = samples_checked + 1;
        if (got < exp - tol || got > exp + tol)
        begin
            num_errors = num_errors + 1;
            $display("unexpected %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task complete_run;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        #1 check_val(width_steps_o, 6'h05);
        cur = 6'h05;
        // Corner widths first and last, random ones between, all before any fix.
        for (k = 0; k < 12; k = k + 1)
        begin
            s = (k == 0) ? 6'h00 : (k == 1) ? 6'h0a : (k == 2) ? 6'h01 :
                (k == 11) ? 6'h09 : $random(seed) & 6'h0f;
            @(posedge clk_i);
            width_wr_i <= 1'b1;
            width_steps_i <= s;
            @(posedge clk_i);
            width_wr_i <= 1'b0;
            #1 check_val({5'h00, width_reject_o},
                {5'h00, next_width(cur, s) != s});
            cur = next_width(cur, s);
            check_val(width_steps_o, cur);
        end
        repeat (3000) @(posedge clk_i);
        check_cnt(rises, 0, 0);
        fix_valid_i <= 1'b1;
        for (k = 0; k < 5; k = k + 1)
        begin
            r0 = rises;
            h0 = hi;
            @(posedge clk_i);
            second_start_i <= 1'b1;
            @(posedge clk_i);
            second_start_i <= 1'b0;
            repeat (1000 * CPM - 2) @(posedge clk_i);
            #1 check_val({3'h0, sentence_slot_o}, 6'h03);
            if (k > 0)
            begin
                check_cnt(rises - r0, 5, 0);
                check_cnt(hi - h0, 900 * CPM, 5);
            end
        end
        check_val({5'h00, aligned_o}, 6'h01);
        @(posedge clk_i);
        fix_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 check_val({5'h00, aligned_o}, 6'h00);
        complete_run;
    end
    // The run needs about 53000 cycles; cut it off well beyond that.
    initial
    begin
        #(80000 * 100);
        num_errors = num_errors + 1;
        complete_run;
    end
endmodule // fapg_pulse_gen_tb
